// file: csf_pkg.sv
// Package for the core status flags and general register block
package csf_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] STACK_TOP_PTR_OFS  = 8'h81;
   localparam logic [7:0] DATA_PTR_LOW_OFS   = 8'h82;
   localparam logic [7:0] DATA_PTR_HIGH_OFS  = 8'h83;
   localparam logic [7:0] POWER_CTL_OFS      = 8'h87;
   localparam logic [7:0] IDENT_KEY_OFS      = 8'ha1;
   localparam logic [7:0] PROG_STATUS_OFS    = 8'hd0;
   localparam logic [7:0] SYSTEM_CONFIG_OFS  = 8'hd1;
   localparam logic [7:0] MAIN_WORK_OFS      = 8'he0;
   localparam logic [7:0] AUX_ARITH_OFS      = 8'hf0;
   localparam logic [7:0] OP_CONTROL_OFS     = 8'hc8;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] STACK_TOP_RST      = 8'h07;
   localparam logic [7:0] DATA_PTR_RST       = 8'h00;
   localparam logic [7:0] POWER_CTL_RST      = 8'h10;
   localparam logic [7:0] UNLOCK_KEY_RST     = 8'h00;
   localparam logic [7:0] PROG_STATUS_RST    = 8'h00;
   localparam logic [7:0] SYS_CFG_BOOT_RST   = 8'he0;
   localparam logic [7:0] SYS_CFG_APP_RST    = 8'hc0;
   localparam logic [7:0] WORK_REG_RST       = 8'h00;
   // Arbitrary identification value
   localparam logic [7:0] PART_IDENT_VAL     = 8'h3c;
   localparam logic [7:0] BYTE_MAX           = 8'hff;

   // ----------------------------------------------------------------
   // Status word field positions
   // ----------------------------------------------------------------
   localparam int CARRY_BIT    = 7;
   localparam int HALF_BIT     = 6;
   localparam int USER0_BIT    = 5;
   localparam int BANK_HI_BIT  = 4;
   localparam int BANK_LO_BIT  = 3;
   localparam int EXCESS_BIT   = 2;
   localparam int USER1_BIT    = 1;
   localparam int PARITY_BIT   = 0;

   // Operation control register fields (op code in 3:0, start at 7)
   localparam int OP_START_BIT = 7;
   localparam int BANK_WIDTH   = 5;

   // ----------------------------------------------------------------
   // Arithmetic operations
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      CSF_OP_NONE = 4'h0,
      CSF_OP_ADD  = 4'h1,
      CSF_OP_ADDC = 4'h2,
      CSF_OP_SUBB = 4'h3,
      CSF_OP_MUL  = 4'h4,
      CSF_OP_DIV  = 4'h5,
      CSF_OP_SETC = 4'h6,
      CSF_OP_CLRC = 4'h7,
      CSF_OP_CPLC = 4'h8
   } csf_op_t;

   // Register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } csf_bus_req_t;

   // Status flags as seen by the core
   typedef struct packed {
      logic [BANK_WIDTH-1:0] bank_base;
      logic [15:0]           data_ptr_word;
      logic                  parity;
   } csf_view_t;

endpackage

// file: csf_status_flags.sv
// Core status word, arithmetic registers and special register bank
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps

// Notes on behaviour
// - Carry set on add carry-out or subtract borrow, else cleared by arithmetic.
// - Half carry set on carry into or borrow from upper nibble.
// - Excess flag set when add, add-with-carry or subtract changes sign wrongly.
// - Excess flag set when multiply product exceeds 255.
// - Excess flag set when divide has zero divisor.
// - Those five operations clear excess flag when no overflow case occurs.
// - Status word: carry 7, half 6, user 5, bank hi 4, bank lo 3, excess 2.
// - Bit 5 is a free user flag with no hardware effect.
// - Bank select bits pick working register group base 00h, 08h, 10h, 18h.
// - Bit 0 is read-only odd parity of the main work register.
// - Bit 1 is a second free user flag.
// - Aux register is second operand and result holder for multiply and divide.
// - Main work register supports single-bit read and write plus byte access.
// - System config resets to e0h in boot state and c0h in application state.
// - Reads at shared address return the part code; writes never alter it.
// - Writes at shared address go to write-only unlock key, reset zero.
// - Data pointer forms one 16-bit word from low and high bytes, reset zero.
// - Power control register resets to 10h.
module csf_status_flags
(
   // Clock and reset
   input  wire logic                core_clk_i,
   input  wire logic                rstn_i,
   // Boot strap level, taken after reset release
   input  wire logic                boot_state_i,
   // Register port
   input  wire csf_pkg::csf_bus_req_t bus_i,
   output logic [7:0]               rdata_o,
   // Single bit access to main work register
   input  wire logic                bit_wr_i,
   input  wire logic [2:0]          bit_sel_i,
   input  wire logic                bit_val_i,
   output logic                     bit_rd_o,
   // Core view of status
   output csf_pkg::csf_view_t       view_o,
   output logic [7:0]               unlock_key_o
);
   import csf_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Odd parity of a byte
   function automatic logic odd_par(input logic [7:0] v);
      odd_par = ^v;
   endfunction

   // Register write hit
   function automatic logic wr_hit(input csf_bus_req_t req, input logic [7:0] ofs);
      wr_hit = req.wr && (req.addr == ofs);
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0] work_q;
   logic [7:0] aux_q;
   logic [7:0] status_q;
   logic [7:0] stack_q;
   logic [7:0] data_ptr_word_lo_q;
   logic [7:0] data_ptr_word_hi_q;
   logic [7:0] power_q;
   logic [7:0] key_q;
   logic [7:0] cfg_q;
   logic       strap_done_q;
   logic [7:0] rdata_q;
   logic       bit_rd_q;
   csf_view_t  view_q;

   // Operation decode
   csf_op_t    op;
   logic       op_go;
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic       ovf_add;
   logic [15:0] prod;
   logic [7:0] res_a;
   logic [7:0] res_aux;
   logic       nxt_carry;
   logic       nxt_half;
   logic       nxt_excess;
   logic       arith;
   logic       upd_carry;

   assign op    = csf_op_t'(bus_i.wdata[3:0]);
   assign op_go = wr_hit(bus_i, OP_CONTROL_OFS) && bus_i.wdata[OP_START_BIT];

   // ----------------------------------------------------------------
   // Arithmetic flag evaluation
   // ----------------------------------------------------------------
   // Result and flags for the requested operation
   always_comb
   begin
      sum9    = 9'h000;
      sum5    = 5'h00;
      ovf_add = 1'b0;
      prod    = 16'h0000;
      res_a      = work_q;
      res_aux    = aux_q;
      nxt_carry  = status_q[CARRY_BIT];
      nxt_half   = status_q[HALF_BIT];
      nxt_excess = status_q[EXCESS_BIT];
      arith      = 1'b0;
      upd_carry  = 1'b0;
      case (op)
         CSF_OP_ADD, CSF_OP_ADDC:
         begin
            arith      = 1'b1;
            sum9       = {1'b0, work_q} + {1'b0, aux_q}
                         + {8'h00, (op == CSF_OP_ADDC) & status_q[CARRY_BIT]};
            sum5       = {1'b0, work_q[3:0]} + {1'b0, aux_q[3:0]}
                         + {4'h0, (op == CSF_OP_ADDC) & status_q[CARRY_BIT]};
            res_a      = sum9[7:0];
            nxt_carry  = sum9[8];
            nxt_half   = sum5[4];
            ovf_add    = (work_q[7] == aux_q[7]) && (sum9[7] != work_q[7]);
            nxt_excess = ovf_add;
         end
         CSF_OP_SUBB:
         begin
            arith      = 1'b1;
            sum9       = {1'b0, work_q} - {1'b0, aux_q} - {8'h00, status_q[CARRY_BIT]};
            sum5       = {1'b0, work_q[3:0]} - {1'b0, aux_q[3:0]}
                         - {4'h0, status_q[CARRY_BIT]};
            res_a      = sum9[7:0];
            nxt_carry  = sum9[8];
            nxt_half   = sum5[4];
            ovf_add    = (work_q[7] != aux_q[7]) && (sum9[7] != work_q[7]);
            nxt_excess = ovf_add;
         end
         CSF_OP_MUL:
         begin
            arith      = 1'b1;
            prod       = {8'h00, work_q} * {8'h00, aux_q};
            res_a      = prod[7:0];
            res_aux    = prod[15:8];
            nxt_carry  = 1'b0;
            nxt_half   = 1'b0;
            nxt_excess = (prod[15:8] != 8'h00);
         end
         CSF_OP_DIV:
         begin
            arith     = 1'b1;
            nxt_carry = 1'b0;
            nxt_half  = 1'b0;
            if (aux_q == 8'h00)
            begin
               nxt_excess = 1'b1;
               res_a      = BYTE_MAX;
               res_aux    = BYTE_MAX;
            end
            else
            begin
               nxt_excess = 1'b0;
               res_a      = work_q / aux_q;
               res_aux    = work_q % aux_q;
            end
         end
         CSF_OP_SETC:
         begin
            upd_carry = 1'b1;
            nxt_carry = 1'b1;
         end
         CSF_OP_CLRC:
         begin
            upd_carry = 1'b1;
            nxt_carry = 1'b0;
         end
         CSF_OP_CPLC:
         begin
            upd_carry = 1'b1;
            nxt_carry = ~status_q[CARRY_BIT];
         end
         default:
         begin
            arith = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Main work register
   // ----------------------------------------------------------------
   // Byte write, bit write and operation result
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         work_q <= WORK_REG_RST;
      else if (op_go && arith)
         work_q <= res_a;
      else if (wr_hit(bus_i, MAIN_WORK_OFS))
         work_q <= bus_i.wdata;
      else if (bit_wr_i)
         work_q[bit_sel_i] <= bit_val_i;
   end

   // Aux register, second operand and high result
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         aux_q <= WORK_REG_RST;
      else if (op_go && (op == CSF_OP_MUL || op == CSF_OP_DIV))
         aux_q <= res_aux;
      else if (wr_hit(bus_i, AUX_ARITH_OFS))
         aux_q <= bus_i.wdata;
   end

   // ----------------------------------------------------------------
   // Status word
   // ----------------------------------------------------------------
   // Software write, then hardware flag update wins
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         status_q <= PROG_STATUS_RST;
      else
      begin
         if (wr_hit(bus_i, PROG_STATUS_OFS))
            status_q <= {bus_i.wdata[7:1], 1'b0};
         if (op_go && arith)
         begin
            status_q[CARRY_BIT]  <= nxt_carry;
            status_q[HALF_BIT]   <= nxt_half;
            status_q[EXCESS_BIT] <= nxt_excess;
         end
         else if (op_go && upd_carry)
            status_q[CARRY_BIT]  <= nxt_carry;
      end
   end

   // ----------------------------------------------------------------
   // Pointer, power and key registers
   // ----------------------------------------------------------------
   // Stack pointer
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         stack_q <= STACK_TOP_RST;
      else if (wr_hit(bus_i, STACK_TOP_PTR_OFS))
         stack_q <= bus_i.wdata;
   end

   // Data pointer halves
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         data_ptr_word_lo_q <= DATA_PTR_RST;
         data_ptr_word_hi_q <= DATA_PTR_RST;
      end
      else
      begin
         if (wr_hit(bus_i, DATA_PTR_LOW_OFS))
            data_ptr_word_lo_q <= bus_i.wdata;
         if (wr_hit(bus_i, DATA_PTR_HIGH_OFS))
            data_ptr_word_hi_q <= bus_i.wdata;
      end
   end

   // Power control
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         power_q <= POWER_CTL_RST;
      else if (wr_hit(bus_i, POWER_CTL_OFS))
         power_q <= bus_i.wdata;
   end

   // Unlock key, write-only at the shared address
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         key_q <= UNLOCK_KEY_RST;
      else if (wr_hit(bus_i, IDENT_KEY_OFS))
         key_q <= bus_i.wdata;
   end

   // System config, reset value chosen by strap after release
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cfg_q        <= SYS_CFG_BOOT_RST;
         strap_done_q <= 1'b0;
      end
      else if (!strap_done_q)
      begin
         strap_done_q <= 1'b1;
         cfg_q <= boot_state_i ? SYS_CFG_BOOT_RST : SYS_CFG_APP_RST;
      end
      else if (wr_hit(bus_i, SYSTEM_CONFIG_OFS))
         cfg_q <= {cfg_q[7:5], bus_i.wdata[4:0]};
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         rdata_q <= 8'h00;
      else if (bus_i.rd)
      begin
         case (bus_i.addr)
            STACK_TOP_PTR_OFS: rdata_q <= stack_q;
            DATA_PTR_LOW_OFS:  rdata_q <= data_ptr_word_lo_q;
            DATA_PTR_HIGH_OFS: rdata_q <= data_ptr_word_hi_q;
            POWER_CTL_OFS:     rdata_q <= power_q;
            IDENT_KEY_OFS:     rdata_q <= PART_IDENT_VAL;
            PROG_STATUS_OFS:   rdata_q <= {status_q[7:1], odd_par(work_q)};
            SYSTEM_CONFIG_OFS: rdata_q <= cfg_q;
            MAIN_WORK_OFS:     rdata_q <= work_q;
            AUX_ARITH_OFS:     rdata_q <= aux_q;
            default:           rdata_q <= 8'h00;
         endcase
      end
      else
         rdata_q <= 8'h00;
   end

   // Bit read and core view
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         bit_rd_q <= 1'b0;
         view_q   <= '0;
      end
      else
      begin
         bit_rd_q                <= work_q[bit_sel_i];
         view_q.bank_base        <= {status_q[BANK_HI_BIT],
                                     status_q[BANK_LO_BIT], 3'b000};
         view_q.data_ptr_word    <= {data_ptr_word_hi_q, data_ptr_word_lo_q};
         view_q.parity           <= odd_par(work_q);
      end
   end

   assign rdata_o      = rdata_q;
   assign bit_rd_o     = bit_rd_q;
   assign view_o       = view_q;
   assign unlock_key_o = key_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   add_carry_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      op_go && op == CSF_OP_ADD |=> status_q[CARRY_BIT] ==
         ((({1'b0, $past(work_q)} + {1'b0, $past(aux_q)}) >> 8) != 9'h000))
      else $error("carry wrong after add");
   half_carry_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      op_go && op == CSF_OP_ADD |=> status_q[HALF_BIT] ==
         (({1'b0, $past(work_q[3:0])} + {1'b0, $past(aux_q[3:0])}) > 5'h0f))
      else $error("half carry wrong after add");
   mul_over_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      op_go && op == CSF_OP_MUL |=> status_q[EXCESS_BIT] ==
         (({8'h00, $past(work_q)} * {8'h00, $past(aux_q)}) > 16'h00ff))
      else $error("excess flag wrong after multiply");
   div_zero_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      op_go && op == CSF_OP_DIV && aux_q == 8'h00 |=> status_q[EXCESS_BIT]
         && !status_q[CARRY_BIT])
      else $error("divide by zero not flagged");
   flag_hold_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !op_go && !wr_hit(bus_i, PROG_STATUS_OFS) |=> $stable(status_q))
      else $error("status flags changed without cause");
   parity_out_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      bus_i.rd && bus_i.addr == PROG_STATUS_OFS |=> rdata_o[0] == ^$past(work_q))
      else $error("parity bit wrong on read");
   ident_read_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      bus_i.rd && bus_i.addr == IDENT_KEY_OFS |=> rdata_o == PART_IDENT_VAL)
      else $error("part code wrong on read");
   key_write_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      wr_hit(bus_i, IDENT_KEY_OFS) |=> unlock_key_o == $past(bus_i.wdata))
      else $error("unlock key not written");
   data_ptr_word_word_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      ##1 view_o.data_ptr_word == {$past(data_ptr_word_hi_q), $past(data_ptr_word_lo_q)})
      else $error("data pointer word mismatch");

endmodule

// file: csf_status_flags_bench.sv
// Self-checking bench for the core status flags block
`timescale 1ns/1ps
module csf_status_flags_bench;
   import csf_pkg::*;

   // ------------------------------------------------------------
   // Stimulus and observation signals
   // ------------------------------------------------------------
   logic         core_clk_i   = 1'b0;
   logic         rstn_i       = 1'b0;
   logic         boot_state_i = 1'b1;
   csf_bus_req_t bus_i        = '0;
   logic [7:0]   rdata_o;
   logic         bit_wr_i     = 1'b0;
   logic [2:0]   bit_sel_i    = 3'h0;
   logic         bit_val_i    = 1'b0;
   logic         bit_rd_o;
   csf_view_t    view_o;
   logic [7:0]   unlock_key_o;
   logic         bit_chk      = 1'b0;
   logic         rd_seen      = 1'b0;
   logic         bit_seen     = 1'b0;
   logic [7:0]   rd_q[$];
   logic         bit_q[$];
   logic [7:0]   ma;
   logic [7:0]   my;
   logic [7:0]   mp;
   logic [31:0]  rb;
   integer       seed         = 32'h437279ea;
   int           fail_count   = 0;
   int           check_count  = 0;
   int           cyc          = 0;
   int           k;

   // Clock, 100 ns period
   always #50 core_clk_i = ~core_clk_i;

   csf_status_flags i_dut (
      .core_clk_i   (core_clk_i),
      .rstn_i       (rstn_i),
      .boot_state_i (boot_state_i),
      .bus_i        (bus_i),
      .rdata_o      (rdata_o),
      .bit_wr_i     (bit_wr_i),
      .bit_sel_i    (bit_sel_i),
      .bit_val_i    (bit_val_i),
      .bit_rd_o     (bit_rd_o),
      .view_o       (view_o),
      .unlock_key_o (unlock_key_o)
   );

   // ------------------------------------------------------------
   // Compare, report and bus tasks
   // ------------------------------------------------------------
   task chk_val(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t bit got=%h exp=%h", $time, got, exp);
      end
   endtask

   task wrap_up;
      $display("Checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Strobes held until the next call; idle drops them
   task wr(input logic [7:0] a, input logic [7:0] d);
      bus_i <= '{a, d, 1'b1, 1'b0};
      @(posedge core_clk_i);
   endtask

   task rd(input logic [7:0] a, input logic [7:0] exp);
      bus_i <= '{a, 8'h00, 1'b0, 1'b1};
      rd_q.push_back(exp);
      @(posedge core_clk_i);
   endtask

   task idle;
      bus_i    <= '0;
      bit_wr_i <= 1'b0;
      bit_chk  <= 1'b0;
      @(posedge core_clk_i);
   endtask

   // Load operands and status, run one operation, read back against the model
   task do_op(input logic [7:0] a, input logic [7:0] y, input logic [7:0] p,
              input logic [3:0] op);
      logic [8:0]  s;
      logic [15:0] pr;
      logic        cin;
      wr(MAIN_WORK_OFS, a);
      wr(AUX_ARITH_OFS, y);
      wr(PROG_STATUS_OFS, p);
      wr(OP_CONTROL_OFS, {4'h8, op});
      idle;
      ma  = a;
      my  = y;
      mp  = p;
      cin = p[CARRY_BIT];
      case (op)
         4'h1, 4'h2:
         begin
            if (op == 4'h1)
               cin = 1'b0;
            s  = {1'b0, a} + {1'b0, y} + {8'h00, cin};
            ma = s[7:0];
            mp[CARRY_BIT]  = s[8];
            mp[HALF_BIT]   = ({1'b0, a[3:0]} + {1'b0, y[3:0]} + {4'h0, cin}) > 5'h0f;
            mp[EXCESS_BIT] = (a[7] == y[7]) && (s[7] != a[7]);
         end
         4'h3:
         begin
            s  = {1'b0, a} - {1'b0, y} - {8'h00, cin};
            ma = s[7:0];
            mp[CARRY_BIT]  = s[8];
            mp[HALF_BIT]   = {1'b0, a[3:0]} < ({1'b0, y[3:0]} + {4'h0, cin});
            mp[EXCESS_BIT] = (a[7] != y[7]) && (s[7] != a[7]);
         end
         4'h4:
         begin
            pr = {8'h00, a} * {8'h00, y};
            ma = pr[7:0];
            my = pr[15:8];
            mp[EXCESS_BIT] = pr > 16'h00ff;
         end
         4'h5:
         begin
            ma = (y == 8'h00) ? BYTE_MAX : a / y;
            my = (y == 8'h00) ? BYTE_MAX : a % y;
            mp[EXCESS_BIT] = y == 8'h00;
         end
         4'h6: mp[CARRY_BIT] = 1'b1;
         4'h7: mp[CARRY_BIT] = 1'b0;
         default: mp[CARRY_BIT] = ~p[CARRY_BIT];
      endcase
      if (op == 4'h4 || op == 4'h5)
      begin
         mp[CARRY_BIT] = 1'b0;
         mp[HALF_BIT]  = 1'b0;
      end
      rd(MAIN_WORK_OFS, ma);
      rd(AUX_ARITH_OFS, my);
      rd(PROG_STATUS_OFS, {mp[7:1], ^ma});
   endtask

   // ------------------------------------------------------------
   // Output monitor: pops the oldest note when a result is due
   // ------------------------------------------------------------
   always @(posedge core_clk_i)
   begin
      if (rd_seen)
         chk_val({8'h00, rdata_o}, {8'h00, rd_q.pop_front()});
      if (bit_seen)
         chk_bit(bit_rd_o, bit_q.pop_front());
      rd_seen  <= bus_i.rd;
      bit_seen <= bit_chk;
   end

   // Hang guard
   always @(posedge core_clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fail_count++;
         wrap_up;
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      idle;
      idle;
      rd(STACK_TOP_PTR_OFS, STACK_TOP_RST);
      rd(DATA_PTR_LOW_OFS, DATA_PTR_RST);
      rd(DATA_PTR_HIGH_OFS, DATA_PTR_RST);
      rd(POWER_CTL_OFS, POWER_CTL_RST);
      rd(IDENT_KEY_OFS, PART_IDENT_VAL);
      rd(PROG_STATUS_OFS, PROG_STATUS_RST);
      rd(SYSTEM_CONFIG_OFS, SYS_CFG_BOOT_RST);
      rd(MAIN_WORK_OFS, WORK_REG_RST);
      rd(AUX_ARITH_OFS, WORK_REG_RST);
      rd(8'h55, 8'h00);
      rd(OP_CONTROL_OFS, 8'h00);
      idle;
      chk_val({8'h00, unlock_key_o}, {8'h00, UNLOCK_KEY_RST});
      // Back-to-back writes, shared address, config
      wr(STACK_TOP_PTR_OFS, 8'h3c);
      wr(DATA_PTR_LOW_OFS, 8'h34);
      wr(DATA_PTR_HIGH_OFS, 8'h12);
      wr(POWER_CTL_OFS, 8'ha5);
      wr(IDENT_KEY_OFS, 8'h5a);
      wr(SYSTEM_CONFIG_OFS, 8'h0d);
      rd(STACK_TOP_PTR_OFS, 8'h3c);
      rd(POWER_CTL_OFS, 8'ha5);
      rd(IDENT_KEY_OFS, PART_IDENT_VAL);
      rd(SYSTEM_CONFIG_OFS, SYS_CFG_BOOT_RST | 8'h0d);
      idle;
      idle;
      chk_val(view_o.data_ptr_word, 16'h1234);
      chk_val({8'h00, unlock_key_o}, 16'h005a);
      // Every register bank
      for (k = 0; k < 4; k++)
      begin
         wr(PROG_STATUS_OFS, {3'b000, k[1:0], 3'b000});
         idle;
         idle;
         chk_val({11'h000, view_o.bank_base}, 16'(k * 8));
      end
      // User flags and read-only parity
      wr(MAIN_WORK_OFS, 8'h07);
      wr(PROG_STATUS_OFS, 8'h22);
      rd(PROG_STATUS_OFS, 8'h23);
      wr(MAIN_WORK_OFS, 8'h03);
      wr(PROG_STATUS_OFS, 8'h21);
      rd(PROG_STATUS_OFS, 8'h20);
      idle;
      idle;
      chk_bit(view_o.parity, 1'b0);
      // Arithmetic boundaries
      do_op(8'h7f, 8'h01, 8'h00, CSF_OP_ADD);
      do_op(8'hff, 8'h01, 8'h00, CSF_OP_ADD);
      do_op(8'h0f, 8'h00, 8'h80, CSF_OP_ADDC);
      do_op(8'h80, 8'h01, 8'h00, CSF_OP_SUBB);
      do_op(8'h00, 8'h00, 8'h80, CSF_OP_SUBB);
      do_op(8'h0f, 8'h11, 8'hc4, CSF_OP_MUL);
      do_op(8'h10, 8'h10, 8'h00, CSF_OP_MUL);
      do_op(8'h64, 8'h00, 8'h00, CSF_OP_DIV);
      do_op(8'h64, 8'h07, 8'hc4, CSF_OP_DIV);
      do_op(8'h12, 8'h34, 8'h44, CSF_OP_SETC);
      do_op(8'h12, 8'h34, 8'hc4, CSF_OP_CLRC);
      do_op(8'h12, 8'h34, 8'h44, CSF_OP_CPLC);
      for (k = 0; k < 40; k++)
      begin
         rb = $random(seed);
         do_op(rb[7:0], rb[15:8], rb[23:16], {1'b0, rb[26:24]} + 4'h1);
      end
      // Drop the last read strobe before the bit accesses
      idle;
      // Single-bit writes then single-bit reads
      for (k = 0; k < 8; k++)
      begin
         rb = $random(seed);
         bit_wr_i  <= 1'b1;
         bit_sel_i <= k[2:0];
         bit_val_i <= rb[0];
         ma[k] = rb[0];
         @(posedge core_clk_i);
      end
      idle;
      for (k = 0; k < 8; k++)
      begin
         bit_sel_i <= k[2:0];
         bit_chk   <= 1'b1;
         bit_q.push_back(ma[k]);
         @(posedge core_clk_i);
      end
      idle;
      rd(MAIN_WORK_OFS, ma);
      idle;
      // Second reset in application state
      rstn_i       <= 1'b0;
      boot_state_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      chk_val({8'h00, unlock_key_o}, 16'h0000);
      rstn_i <= 1'b1;
      idle;
      idle;
      rd(SYSTEM_CONFIG_OFS, SYS_CFG_APP_RST);
      rd(DATA_PTR_HIGH_OFS, DATA_PTR_RST);
      rd(POWER_CTL_OFS, POWER_CTL_RST);
      idle;
      idle;
      wrap_up;
   end

endmodule
